// File: design/ihm_defines.vh
// Purpose: constants for the indirect host microport
// Assumes: 8-bit external port, 11-bit internal address, 32-bit internal data
// Notes: included by ihm_strap and ihm_microport; ihm_sync2 does not include it
`ifndef IHM_DEFINES_VH
`define IHM_DEFINES_VH

`define IHM_EXT_DATA_BYTE_0      3'h0
`define IHM_EXT_DATA_BYTE_1      3'h1
`define IHM_EXT_DATA_BYTE_2      3'h2
`define IHM_EXT_DATA_BYTE_3      3'h3
`define IHM_EXT_CHRESET    3'h4
`define IHM_EXT_SYNC       3'h5
`define IHM_EXT_ADDR_LO    3'h6
`define IHM_EXT_ADDR_HI    3'h7

`define IHM_HI_RDINC_BIT   6
`define IHM_HI_WRINC_BIT   7
`define IHM_SYNC_START_BIT 4
`define IHM_SYNC_HOP_BIT   5
`define IHM_SYNC_BEAM_BIT  6

`define IHM_CHRESET_RST    8'h00
`define IHM_ADDR_HI_RST    8'h00
`define IHM_ADDR_LO_RST    8'h00

`define IHM_CONV_SEPARATE  1'b0
`define IHM_CONV_DSTROBE   1'b1

// internal access length in master clocks
`define IHM_INT_CYCLES     2

`endif

// File: design/ihm_sync2.v
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: inputs are asynchronous to clock
// Notes: first stage read only by second stage
`timescale 1ns/10ps
module ihm_sync2 #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             clock,
	input  wire             rst_b,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta_r;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule // ihm_sync2

// File: design/ihm_strap.v
// Purpose: capture the bus-convention strap after reset release
// Assumes: strap input already synchronised
// Notes: held constant once caught at the third clock following reset
`timescale 1ns/10ps
`include "ihm_defines.vh"
module ihm_strap (
	input  wire clock,
	input  wire rst_b,
	input  wire strap_sync,
	output reg  convention_r
);
	reg [1:0] wait_r;

	// synchroniser shows its reset value for two edges; catch only after that
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wait_r       <= 2'h0;
			convention_r <= `IHM_CONV_SEPARATE;
		end else if (wait_r != 2'h3) begin
			wait_r       <= wait_r + 2'h1;
			if (wait_r == 2'h2) begin
				convention_r <= strap_sync;
			end
		end
	end
endmodule // ihm_strap

// File: design/ihm_microport.v
// Purpose: eight-bit asynchronous host port reaching a 2K x 32 internal space indirectly
// Assumes: host pins asynchronous to clock; internal space answers in two clocks
// Notes: transfer_ack_n is open drain, shown as out/enable pair
`timescale 1ns/10ps
`include "ihm_defines.vh"

// Overview of operation
// [R1] strap low: separate read/write strobes; strap high: data strobe plus read-not-write
// [R2] host sees only a 3-bit address and 8-bit two-way data bus
// [R3] external addresses 0..3 hold the data word, 0 least significant byte
// [R4] address 4 is channel reset register; start sync clears that channel's bit
// [R5] writes to addresses 4 and 5 act immediately, no internal access
// [R6] sync write: bit4 start, bit5 hop, bit6 beam, bits3..0 channels D..A
// [R7] sync register is write only; reading it gives zero
// [R8] internal space has 11-bit address and 32-bit data
// [R9] address 7 bits 2..0 hold the upper three internal address bits
// [R10] address 6 holds the lower eight internal address bits
// [R11] address 7 bit6 increments after reads, bit7 after writes
// [R12] writing byte 0 launches the internal write; write higher bytes first
// [R13] reading byte 0 launches the internal read and returns low byte
// [R14] fetched word stays in bytes 1..3 for reading in any order
// [R15] each internal read or write takes two master clocks
// [R16] a 16-bit write uses byte 1 then byte 0 after both addresses
// [R17] the address registers may be loaded in either order before the access
// [R18] chip select may stay low; each strobe pulse is a fresh access
// [R19] separate strobes: wait goes low at access start, released when done
// [R20] data strobe: ack low when done, high after the strobe is released
// [R21] acknowledge is an open-drain output
// [R22] reset register bits 7..4 program enables, bits 3..0 channel wake
// [R23] wait or ack stays busy until the two-cycle internal transfer ends
module ihm_microport (
	input  wire        clock,
	input  wire        rst_b,
	input  wire        convention_strap,
	input  wire        chip_sel_n,
	input  wire        rd_n,
	input  wire        wr_n,
	input  wire [2:0]  ext_addr,
	input  wire [7:0]  data_in,
	output reg  [7:0]  data_out,
	output reg         data_oe,
	output reg         ready_r,
	output reg         transfer_ack_n,
	output reg         transfer_ack_oe,
	output reg  [10:0] int_addr,
	output reg  [31:0] int_wdata,
	output reg         int_wr,
	output reg         int_rd,
	input  wire [31:0] int_rdata,
	output reg  [3:0]  prog_enable,
	output reg  [3:0]  chan_awake,
	output reg  [3:0]  start_sync,
	output reg  [3:0]  hop_sync,
	output reg  [3:0]  beam_sync
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_INT1 = 5'h02;
	localparam [4:0] ST_INT2 = 5'h04;
	localparam [4:0] ST_DONE = 5'h08;
	localparam [4:0] ST_HOLD = 5'h10;

	wire        cs_s;
	wire        rd_s;
	wire        wr_s;
	wire [2:0]  addr_s;
	wire [7:0]  din_s;
	wire        strap_s;
	wire        conv;

	reg  [4:0]  state_r;
	reg  [4:0]  state_nxt;
	reg         is_read_r;
	reg  [2:0]  acc_addr_r;
	reg  [7:0]  byte_r [0:3];
	reg  [7:0]  chreset_r;
	reg  [7:0]  addr_lo_r;
	reg  [7:0]  addr_hi_r;
	reg         ihm_phase_r;

	// pin inputs, all through two flops; active-low pins made active high
	ihm_sync2 #(
		.WIDTH   (15),
		.RST_VAL (15'h0000)
	) u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.din   ({~chip_sel_n, ~rd_n, ~wr_n, ext_addr, data_in, convention_strap}),
		.dout  ({cs_s, rd_s, wr_s, addr_s, din_s, strap_s})
	);

	ihm_strap u_strap (
		.clock        (clock),
		.rst_b        (rst_b),
		.strap_sync   (strap_s),
		.convention_r (conv)
	);

	// access request per convention
	wire strobe_sep = cs_s & (rd_s | wr_s);        // [R1]
	wire strobe_ds  = cs_s & rd_s;                 // [R1]
	wire access_on  = (conv == `IHM_CONV_DSTROBE) ? strobe_ds : strobe_sep;
	wire access_rd  = (conv == `IHM_CONV_DSTROBE) ? ~wr_s : rd_s; // [R1] r/w pin high means read
	wire needs_int  = (addr_s == `IHM_EXT_DATA_BYTE_0);  // [R12] [R13]

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (access_on) begin
					state_nxt = needs_int ? ST_INT1 : ST_DONE; // [R5]
				end
			end
			ST_INT1: state_nxt = ST_INT2;                  // [R15]
			ST_INT2: state_nxt = ST_DONE;                  // [R15]
			ST_DONE: state_nxt = ST_HOLD;
			ST_HOLD: begin
				// a new access needs a fresh strobe pulse
				if (!access_on) begin
					state_nxt = ST_IDLE;                   // [R18]
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	wire [10:0] cur_addr = {addr_hi_r[2:0], addr_lo_r}; // [R8] [R9] [R10] [R17]
	wire        inc_rd   = addr_hi_r[`IHM_HI_RDINC_BIT];
	wire        inc_wr   = addr_hi_r[`IHM_HI_WRINC_BIT];
	wire        take     = (state_r == ST_IDLE) & access_on;
	wire        fin_int  = (state_r == ST_INT2);
	wire [10:0] addr_inc = cur_addr + 11'h001;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r     <= ST_IDLE;
			is_read_r   <= 1'b0;
			acc_addr_r  <= 3'h0;
			chreset_r   <= `IHM_CHRESET_RST;
			addr_lo_r   <= `IHM_ADDR_LO_RST;
			addr_hi_r   <= `IHM_ADDR_HI_RST;
			int_addr    <= 11'h000;
			int_wdata   <= 32'h00000000;
			int_wr      <= 1'b0;
			int_rd      <= 1'b0;
			start_sync  <= 4'h0;
			hop_sync    <= 4'h0;
			beam_sync   <= 4'h0;
			ihm_phase_r <= 1'b0;
			byte_r[0]   <= 8'h00;
			byte_r[1]   <= 8'h00;
			byte_r[2]   <= 8'h00;
			byte_r[3]   <= 8'h00;
		end else begin
			state_r    <= state_nxt;
			int_wr     <= 1'b0;
			int_rd     <= 1'b0;
			start_sync <= 4'h0;
			hop_sync   <= 4'h0;
			beam_sync  <= 4'h0;
			if (take) begin
				is_read_r  <= access_rd;
				acc_addr_r <= addr_s;
				if (!access_rd) begin
					case (addr_s)
						`IHM_EXT_DATA_BYTE_0: begin
							byte_r[0] <= din_s;
							int_addr  <= cur_addr;
							int_wdata <= {byte_r[3], byte_r[2], byte_r[1], din_s}; // [R12] [R3]
							int_wr    <= 1'b1;
						end
						`IHM_EXT_DATA_BYTE_1: byte_r[1] <= din_s;  // [R3]
						`IHM_EXT_DATA_BYTE_2: byte_r[2] <= din_s;
						`IHM_EXT_DATA_BYTE_3: byte_r[3] <= din_s;
						`IHM_EXT_CHRESET: chreset_r <= din_s; // [R4] [R22]
						`IHM_EXT_SYNC: begin
							// one-cycle sync pulses to selected channels
							if (din_s[`IHM_SYNC_START_BIT]) begin
								start_sync <= din_s[3:0];       // [R6]
								chreset_r[3:0] <= chreset_r[3:0] & ~din_s[3:0]; // [R4]
							end
							if (din_s[`IHM_SYNC_HOP_BIT]) begin
								hop_sync <= din_s[3:0];         // [R6]
							end
							if (din_s[`IHM_SYNC_BEAM_BIT]) begin
								beam_sync <= din_s[3:0];        // [R6]
							end
						end
						`IHM_EXT_ADDR_LO: addr_lo_r <= din_s;  // [R10]
						`IHM_EXT_ADDR_HI: addr_hi_r <= din_s;  // [R9] [R11]
						default: ;
					endcase
				end else if (addr_s == `IHM_EXT_DATA_BYTE_0) begin
					int_addr <= cur_addr;
					int_rd   <= 1'b1;                        // [R13]
				end
			end
			if (state_r == ST_INT1) begin
				ihm_phase_r <= 1'b1;
			end
			if (fin_int) begin
				ihm_phase_r <= 1'b0;
				if (is_read_r) begin
					// fetched word held for later byte reads
					byte_r[0] <= int_rdata[7:0];               // [R14]
					byte_r[1] <= int_rdata[15:8];
					byte_r[2] <= int_rdata[23:16];
					byte_r[3] <= int_rdata[31:24];
				end
				if ((is_read_r & inc_rd) | (!is_read_r & inc_wr)) begin
					addr_lo_r      <= addr_inc[7:0];           // [R11]
					addr_hi_r[2:0] <= addr_inc[10:8];
				end
			end
		end
	end

	// read mux; sync register reads zero
	reg [7:0] rd_mux;
	always @* begin
		case (acc_addr_r)
			`IHM_EXT_DATA_BYTE_0:   rd_mux = byte_r[0];         // [R13]
			`IHM_EXT_DATA_BYTE_1:   rd_mux = byte_r[1];         // [R14]
			`IHM_EXT_DATA_BYTE_2:   rd_mux = byte_r[2];
			`IHM_EXT_DATA_BYTE_3:   rd_mux = byte_r[3];
			`IHM_EXT_CHRESET: rd_mux = chreset_r;
			`IHM_EXT_SYNC:    rd_mux = 8'h00;             // [R7]
			`IHM_EXT_ADDR_LO: rd_mux = addr_lo_r;
			default:          rd_mux = addr_hi_r;
		endcase
	end

	wire busy = (state_r == ST_IDLE) ? access_on :
	            ((state_r == ST_INT1) | (state_r == ST_INT2)); // [R23]

	// handshake and data pins
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			data_out        <= 8'h00;
			data_oe         <= 1'b0;
			ready_r         <= 1'b1;
			transfer_ack_n  <= 1'b0;
			transfer_ack_oe <= 1'b0;
			prog_enable     <= 4'h0;
			chan_awake      <= 4'h0;
		end else begin
			prog_enable <= chreset_r[7:4];                   // [R22]
			chan_awake  <= chreset_r[3:0];                   // [R22]
			data_out    <= rd_mux;                           // [R2]
			// data driven only once the answer is valid
			data_oe     <= is_read_r & access_on &
			               ((state_r == ST_DONE) | (state_r == ST_HOLD)); // [R2]
			if (conv == `IHM_CONV_SEPARATE) begin
				ready_r         <= ~busy;                    // [R19] [R23]
				transfer_ack_oe <= 1'b0;
			end else begin
				ready_r         <= 1'b1;
				// ack pulled low from done until strobe drops
				transfer_ack_oe <= access_on &
				                   ((state_r == ST_DONE) | (state_r == ST_HOLD)); // [R20] [R21]
			end
			transfer_ack_n <= 1'b0;                          // [R21]
		end
	end
endmodule // ihm_microport

// File: tb/ihm_chk.sv
// Purpose: port assertions for the microport
// Assumes: strap changes only while reset is low
// Notes: bound into ihm_microport
`timescale 1ns/10ps
module ihm_chk (
	input wire       clock,
	input wire       rst_b,
	input wire       convention_strap,
	input wire       int_wr,
	input wire       int_rd,
	input wire       ready_r,
	input wire       transfer_ack_n,
	input wire       transfer_ack_oe,
	input wire [3:0] start_sync,
	input wire [3:0] chan_awake
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_wait_busy; !ready_r [*2]; endsequence
	sequence s_ack_busy; !transfer_ack_oe [*2]; endsequence
	property p_wr_pulse; int_wr |=> !int_wr; endproperty
	property p_rd_pulse; int_rd |=> !int_rd; endproperty
	property p_one_dir; !(int_wr && int_rd); endproperty
	property p_wait_hold; (int_wr || int_rd) && !convention_strap |=> s_wait_busy; endproperty
	property p_ack_hold; (int_wr || int_rd) && convention_strap |=> s_ack_busy; endproperty
	property p_ds_no_wait; convention_strap |-> ready_r; endproperty
	property p_sep_no_ack; !convention_strap |-> !transfer_ack_oe; endproperty
	property p_open_drain; transfer_ack_oe |-> !transfer_ack_n; endproperty
	property p_start_pulse; |start_sync |=> start_sync == 4'h0; endproperty
	property p_start_wake; |start_sync |=> (chan_awake & $past(start_sync)) == 4'h0; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
	a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
	a_one_dir: assert property (p_one_dir) else $error("read and write together");
	a_wait_hold: assert property (p_wait_hold) else $error("wait released early");
	a_ack_hold: assert property (p_ack_hold) else $error("ack given early");
	a_ds_no_wait: assert property (p_ds_no_wait) else $error("wait used in strobe mode");
	a_sep_no_ack: assert property (p_sep_no_ack) else $error("ack used in split mode");
	a_open_drain: assert property (p_open_drain) else $error("ack drives high");
	a_start_pulse: assert property (p_start_pulse) else $error("start sync held");
	a_start_wake: assert property (p_start_wake) else $error("start left wake bit");
endmodule // ihm_chk
bind ihm_microport ihm_chk u_chk (.clock(clock), .rst_b(rst_b), .convention_strap(convention_strap),
	.int_wr(int_wr), .int_rd(int_rd), .ready_r(ready_r), .transfer_ack_n(transfer_ack_n),
	.transfer_ack_oe(transfer_ack_oe), .start_sync(start_sync), .chan_awake(chan_awake));

// File: tb/ihm_host.sv
// Purpose: host processor model for both strobe conventions
// Assumes: convention input matches the strap
// Notes: chip select stays low once used
`timescale 1ns/10ps
module ihm_host (
	input logic        clock,
	input logic        conv,
	input logic  [7:0] data_out,
	input logic        ready_r,
	input logic        ack_oe,
	output logic       cs_n,
	output logic       rd_n,
	output logic       wr_n,
	output logic [2:0] addr,
	output logic [7:0] din
);
	initial begin
		{cs_n, rd_n, wr_n, addr, din} = 14'h3800;
	end
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clock);
		cs_n <= 1'b0;
		addr <= a;
		din <= d;
		rd_n <= conv ? 1'b0 : w;
		wr_n <= ~w;
		n = 0;
		repeat (8) @(posedge clock);
		@(negedge clock);
		while (!(conv ? ack_oe : ready_r) && n < 40) begin
			@(negedge clock);
			n++;
		end
		if (n >= 40) begin
			$display("ERROR %0t: host access never answered", $time);
			tb_indirect_host_microport.num_errors++;
			tb_indirect_host_microport.wrap_up;
		end
		q = data_out;
		@(posedge clock);
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		din <= ~d; // released bus must not keep the last byte
		repeat (4) @(posedge clock);
	endtask
endmodule // ihm_host

// File: tb/tb_indirect_host_microport.sv
// Purpose: self-checking bench for the microport
// Assumes: bench models the internal memory
// Notes: runs once per bus convention
`timescale 1ns/10ps
module tb_indirect_host_microport;
	logic        clock, rst_b, strap, clr, cs_n, rd_n, wr_n, doe, rdy, ack_n, ack_oe, iwr, ird;
	logic [2:0]  a, x;
	logic [7:0]  din, dout, q, v;
	logic [10:0] ia, iadr;
	logic [31:0] iwd, ird_q, seed, ew [4];
	logic [3:0]  pe, aw, awx, ss, hs, bs;
	logic [11:0] cap;
	logic [31:0] mem [0:2047];
	int          num_errors = 0;
	int          checks = 0;
	ihm_microport DUT (.clock(clock), .rst_b(rst_b), .convention_strap(strap), .chip_sel_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .ext_addr(a), .data_in(din), .data_out(dout), .data_oe(doe), .ready_r(rdy),
		.transfer_ack_n(ack_n), .transfer_ack_oe(ack_oe), .int_addr(iadr), .int_wdata(iwd), .int_wr(iwr),
		.int_rd(ird), .int_rdata(ird_q), .prog_enable(pe), .chan_awake(aw), .start_sync(ss), .hop_sync(hs),
		.beam_sync(bs));
	ihm_host u_host (.clock(clock), .conv(strap), .data_out(dout), .ready_r(rdy), .ack_oe(ack_oe), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .addr(a), .din(din));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [11:0] sync_exp(input logic [7:0] s);
		return {s[6] ? s[3:0] : 4'h0, s[5] ? s[3:0] : 4'h0, s[4] ? s[3:0] : 4'h0};
	endfunction
	always @(posedge clock) begin
		if (iwr)
			mem[iadr] <= iwd;
		if (ird)
			ird_q <= mem[iadr];
		cap <= clr ? 12'h000 : cap | {bs, hs, ss};
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic set_addr(input logic m);
		for (int r = 0; r < 2; r++)
			u_host.acc(1'b1, 3'h6 + 3'(r ^ m), (r ^ m) ? {5'h18, ia[10:8]} : ia[7:0], q);
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#400000;
		num_errors++;
		wrap_up;
	end
	initial begin
		seed = 32'h13B4A264;
		{rst_b, strap, clr, ird_q, cap} = '0;
		for (int m = 0; m < 2; m++) begin
			rst_b <= 1'b0;
			strap <= m[0];
			repeat (6) @(posedge clock);
			rst_b <= 1'b1;
			repeat (3) @(posedge clock);
			for (int r = 4; r < 8; r++) begin
				u_host.acc(1'b0, r[2:0], 8'h00, q);
				chk({24'h0, q}, 32'h0);
			end
			seed = lfsr(seed);
			ia = m ? seed[10:0] : 11'h7FE; // wraps past the top of the space
			set_addr(m[0]);
			for (int k = 0; k < 4; k++) begin
				seed = lfsr(seed);
				ew[k] = seed;
				for (int b = 3; b >= 0; b--)
					u_host.acc(1'b1, b[2:0], seed[8*b +: 8], q);
				chk(mem[ia + k[10:0]], ew[k]);
			end
			set_addr(~m[0]);
			for (int k = 0; k < 4; k++)
				for (int b = 0; b < 4; b++) begin
					x = (b == 0) ? 3'h0 : 3'(4 - b);
					u_host.acc(1'b0, x, 8'h00, q);
					chk({24'h0, q}, {24'h0, ew[k][8*x +: 8]});
				end
			u_host.acc(1'b1, 3'h4, 8'hFF, q);
			awx = 4'hF;
			chk({24'h0, pe, aw}, 32'hFF);
			for (int j = 0; j < 3; j++) begin
				seed = lfsr(seed);
				v = (j == 0) ? 8'h14 : (j == 1) ? 8'h6F : seed[7:0];
				clr <= 1'b1;
				@(posedge clock);
				clr <= 1'b0;
				u_host.acc(1'b1, 3'h5, v, q);
				chk({20'h0, cap}, {20'h0, sync_exp(v)});
				awx = awx & ~(v[4] ? v[3:0] : 4'h0);
				u_host.acc(1'b0, 3'h4, 8'h00, q);
				chk({24'h0, q}, {24'h0, 4'hF, awx});
			end
		end
		wrap_up;
	end
endmodule // tb_indirect_host_microport
